// >>> logic/csf_pkg.sv
package csf_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CSF_ADDR_PORT_CTL = 8'h20;
    localparam logic [7:0] CSF_ADDR_MODE_CTL = 8'h21;
    localparam logic [7:0] CSF_ADDR_STATUS = 8'h23;
    localparam logic [7:0] CSF_ADDR_CSI_TRANSMIT_CONTROL = 8'h33;
    localparam logic [7:0] CSF_ADDR_PAGE = 8'h4c;
    localparam logic [7:0] CSF_ADDR_REMAP = 8'h72;
    localparam logic [7:0] CSF_ADDR_REMAP_ALT = 8'h70;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] CSF_PORT_CTL_RST = 8'h30;
    localparam logic [7:0] CSF_MODE_CTL_RST = 8'h00;
    localparam logic [7:0] CSF_CSI_TRANSMIT_CONTROL_RST = 8'h00;
    localparam logic [7:0] CSF_PAGE_RST = 8'h01;
    localparam logic [7:0] CSF_REMAP_RST = 8'he4;

    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int CSF_PORT_DIS_LSB = 4;
    localparam int CSF_MODE_SEL_LSB = 2;
    localparam logic [3:0] CSF_SEL_BASIC = 4'h1;
    localparam logic [3:0] CSF_SEL_INTERLEAVE = 4'ha;
    localparam logic [3:0] CSF_SEL_CONCAT = 4'hf;
    localparam int CSF_CSI_EN_BIT = 0;
    localparam int CSF_LANE_LSB = 4;
    localparam int CSF_PAGE_RD_BIT = 4;
    localparam int CSF_STAT_SYNC_BIT = 0;
    localparam int CSF_STAT_LOST_BIT = 1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CSF_CORE_CLK_NS = 40;
    localparam int CSF_SYNC_TIMEOUT_NS = 64000;
    localparam int CSF_SYNC_TIMEOUT_CYC =
        (CSF_SYNC_TIMEOUT_NS + CSF_CORE_CLK_NS - 1) / CSF_CORE_CLK_NS;
    localparam logic [11:0] CSF_TMO_LAST = 12'(CSF_SYNC_TIMEOUT_CYC - 1);

    // ------------------------------------------------------------
    // Packet checks
    // ------------------------------------------------------------
    localparam logic [15:0] CSF_CRC_SEED = 16'hffff;
    localparam logic [15:0] CSF_CRC_POLY = 16'h8408;
    localparam logic [5:0][23:0] CSF_ECC_MASK = {
        24'heffc00, 24'hdf03f0, 24'hb8e38e,
        24'h749a6d, 24'hf2555b, 24'hf12cb7};

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CSF_KIND_LINE = 2'h0,
        CSF_KIND_FS = 2'h1,
        CSF_KIND_FE = 2'h2
    } csf_kind_e;

    typedef enum logic [1:0] {
        CSF_MODE_OFF = 2'h0,
        CSF_MODE_BASIC = 2'h1,
        CSF_MODE_INTERLEAVE = 2'h2,
        CSF_MODE_CONCAT = 2'h3
    } csf_mode_e;

    typedef enum logic [4:0] {
        CSF_ST_ALIGN = 5'h01,
        CSF_ST_HDR = 5'h02,
        CSF_ST_PAY = 5'h04,
        CSF_ST_CRC = 5'h08,
        CSF_ST_NEXT = 5'h10
    } csf_state_e;

    typedef struct packed {
        logic sop;
        logic eop;
        csf_kind_e kind;
        logic [1:0] vc;
        logic [5:0] dt;
        logic [15:0] wc;
        logic [7:0] data;
    } csf_rx_s;

    typedef struct packed {
        logic strobe;
        logic sop;
        logic eop;
        logic [7:0] data;
    } csf_tx_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csf_reg_req_s;

endpackage

// >>> logic/csf_link_edge.sv
`timescale 1ns/100ps
`default_nettype none

module csf_link_edge
    import csf_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Link byte clock
    input wire logic link_clk,
    // One-cycle pulse per link rising edge
    output logic rise
);

    // ------------------------------------------------------------
    // Two-stage synchroniser and edge detect
    // ------------------------------------------------------------
    logic sync1;
    logic sync2;
    logic sync3;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            rise <= 1'b0;
        end else begin
            sync1 <= link_clk;
            sync2 <= sync1;
            sync3 <= sync2;
            rise <= sync2 & ~sync3;
        end
    end

endmodule

`default_nettype wire

// >>> logic/csf_sync_forward.sv
// Overview of operation
// - Basic mode: each sensor frame leaves as its own FS, lines, FE.
// - Basic mode order: FS0, FS1, lines alternating by port, FE0, FE1.
// - Basic mode: each packet carries its own port's mapped channel.
// - On sync failure stop sending; resume at next frame start.
// - While unsynchronised, incoming packets are discarded.
// - Interleave: one FS and one FE per frame; others dropped.
// - Interleave: lines stay separate packets, N times the lines.
// - Concat: one FS/FE, line y of port 0 then port 1 joined.
// - Concat line gets rebuilt header and footer for combined payload.
// - Concat: all packets use channel of lowest forwarded port.
// - Concat payloads joined byte by byte, no padding.
// - Mode register value 0x04 selects basic synchronized forwarding.
// - Mode register value 0x28 selects line interleave forwarding.
// - Mode register value 0x3c selects line concatenated forwarding.
// - Port register 0x00 clears disables, both ports forward.
// - Transmit control 0x1 enables output with four lanes.
// - Per-port channel map: two bits per incoming channel.
// - Synchronized status bit; only the lost flag is cleared on read.
`timescale 1ns/100ps
`default_nettype none

module csf_sync_forward
    import csf_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register access
    input wire csf_reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    // Receive buffers
    input wire csf_rx_s [1:0] rx_beat,
    input wire logic [1:0] rx_valid,
    output logic [1:0] rx_ready,
    // Transmit byte stream
    input wire logic tx_byte_clk,
    output csf_tx_s tx,
    output logic tx_enable,
    output logic [1:0] tx_lane_sel,
    output logic fwd_synced
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic lowest(input logic [1:0] m);
        return m[0] ? 1'b0 : 1'b1;
    endfunction

    function automatic logic [1:0] remap(input logic [7:0] map,
                                         input logic [1:0] vc);
        case (vc)
            2'h0: remap = map[1:0];
            2'h1: remap = map[3:2];
            2'h2: remap = map[5:4];
            default: remap = map[7:6];
        endcase
    endfunction

    function automatic logic is_remap(input logic [7:0] a);
        return (a == CSF_ADDR_REMAP) || (a == CSF_ADDR_REMAP_ALT);
    endfunction

    function automatic logic [7:0] ecc_of(input logic [23:0] d);
        logic [7:0] e;
        e = 8'h00;
        for (int i = 0; i < 6; i++) begin
            e[i] = ^(d & CSF_ECC_MASK[i]);
        end
        return e;
    endfunction

    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[0] ^ b[i]) begin
                r = (r >> 1) ^ CSF_CRC_POLY;
            end else begin
                r = r >> 1;
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] port_ctl;
    logic [7:0] mode_ctl;
    logic [7:0] csi_transmit_control;
    logic [7:0] page;
    logic [1:0][7:0] port_map;
    logic sync_lost;
    logic sync_fail;
    logic synced;
    logic slot;
    csf_mode_e mode;
    csf_mode_e fr_mode;
    logic [1:0] act;
    logic [1:0] fr_act;
    logic run;
    logic in_frame;
    csf_state_e state;
    logic cur;
    csf_kind_e e_kind;
    logic [1:0] hdr_idx;
    logic [1:0][1:0] hd_vc;
    logic [1:0][5:0] hd_dt;
    logic [1:0][15:0] hd_wc;
    logic [15:0] crc;
    logic pay_have;
    logic pay_eop;
    logic [7:0] pay_byte;
    logic [11:0] tmo;
    logic [1:0] rdy;
    logic [1:0] h_fs;
    logic [1:0] h_fe;
    logic [1:0] h_line;
    logic [1:0] drop_mask;
    logic [1:0] keep_drop;
    logic all_fs;
    logic all_fe;
    logic all_line;
    logic all_head;
    logic merged;
    logic more;
    logic e_long;
    logic [1:0] e_vc;
    logic [15:0] e_wc;
    logic [7:0] e_di;
    logic [7:0] hdr_byte;

    // ------------------------------------------------------------
    // Link byte clock edges
    // ------------------------------------------------------------
    csf_link_edge u_edge (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .link_clk(tx_byte_clk),
        .rise(slot)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            port_ctl <= CSF_PORT_CTL_RST;
            mode_ctl <= CSF_MODE_CTL_RST;
            csi_transmit_control <= CSF_CSI_TRANSMIT_CONTROL_RST;
            page <= CSF_PAGE_RST;
            port_map <= {CSF_REMAP_RST, CSF_REMAP_RST};
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                CSF_ADDR_PORT_CTL: port_ctl <= reg_req.wdata;
                CSF_ADDR_MODE_CTL: mode_ctl <= reg_req.wdata;
                CSF_ADDR_CSI_TRANSMIT_CONTROL: csi_transmit_control <= reg_req.wdata;
                CSF_ADDR_PAGE: page <= reg_req.wdata;
                default: begin
                end
            endcase
            for (int p = 0; p < 2; p++) begin
                if (is_remap(reg_req.addr) && page[p]) begin
                    port_map[p] <= reg_req.wdata;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            reg_rdata <= 8'h00;
            case (reg_req.addr)
                CSF_ADDR_PORT_CTL: reg_rdata <= port_ctl;
                CSF_ADDR_MODE_CTL: reg_rdata <= mode_ctl;
                CSF_ADDR_CSI_TRANSMIT_CONTROL: reg_rdata <= csi_transmit_control;
                CSF_ADDR_PAGE: reg_rdata <= page;
                CSF_ADDR_STATUS: begin
                    reg_rdata[CSF_STAT_SYNC_BIT] <= synced;
                    reg_rdata[CSF_STAT_LOST_BIT] <= sync_lost;
                end
                default: begin
                    if (is_remap(reg_req.addr)) begin
                        reg_rdata <= port_map[page[CSF_PAGE_RD_BIT]];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync_lost <= 1'b0;
        end else if (sync_fail) begin
            sync_lost <= 1'b1;
        end else if (reg_req.rd && reg_req.addr == CSF_ADDR_STATUS) begin
            sync_lost <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_enable <= 1'b0;
            tx_lane_sel <= 2'h0;
            fwd_synced <= 1'b0;
        end else begin
            tx_enable <= csi_transmit_control[CSF_CSI_EN_BIT];
            tx_lane_sel <= csi_transmit_control[CSF_LANE_LSB +: 2];
            fwd_synced <= synced;
        end
    end

    // ------------------------------------------------------------
    // Mode decode and head inspection
    // ------------------------------------------------------------
    always_comb begin
        case (mode_ctl[CSF_MODE_SEL_LSB +: 4])
            CSF_SEL_BASIC: mode = CSF_MODE_BASIC;
            CSF_SEL_INTERLEAVE: mode = CSF_MODE_INTERLEAVE;
            CSF_SEL_CONCAT: mode = CSF_MODE_CONCAT;
            default: mode = CSF_MODE_OFF;
        endcase
    end

    assign act = ~port_ctl[CSF_PORT_DIS_LSB +: 2];
    assign run = (mode != CSF_MODE_OFF) && (act != 2'b00)
        && csi_transmit_control[CSF_CSI_EN_BIT];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_head
            assign h_fs[g] = rx_valid[g] && rx_beat[g].sop
                && rx_beat[g].kind == CSF_KIND_FS;
            assign h_fe[g] = rx_valid[g] && rx_beat[g].sop
                && rx_beat[g].kind == CSF_KIND_FE;
            assign h_line[g] = rx_valid[g] && rx_beat[g].sop
                && rx_beat[g].kind == CSF_KIND_LINE;
        end
    endgenerate

    assign drop_mask = in_frame ? ~fr_act : (run ? ~act : 2'b11);
    assign keep_drop = rx_valid & drop_mask & ~rdy;
    assign all_fs = &(h_fs | ~act);
    assign all_fe = &(h_fe | ~fr_act);
    assign all_line = &(h_line | ~fr_act);
    assign all_head = &((rx_valid & {rx_beat[1].sop, rx_beat[0].sop})
        | ~fr_act);

    // ------------------------------------------------------------
    // Packet header build
    // ------------------------------------------------------------
    assign merged = fr_mode != CSF_MODE_BASIC;
    assign e_long = e_kind == CSF_KIND_LINE;
    assign e_vc = (merged && (!e_long || fr_mode == CSF_MODE_CONCAT))
        ? hd_vc[lowest(fr_act)] : hd_vc[cur];
    assign e_wc = (fr_mode == CSF_MODE_CONCAT && e_long)
        ? 16'((fr_act[0] ? hd_wc[0] : 16'h0000)
            + (fr_act[1] ? hd_wc[1] : 16'h0000))
        : hd_wc[cur];
    assign e_di = {e_vc, hd_dt[cur]};
    // Second port follows in basic, and for interleaved lines
    assign more = !cur && fr_act[1] && (fr_mode == CSF_MODE_BASIC
        || (fr_mode == CSF_MODE_INTERLEAVE && e_long));

    always_comb begin
        case (hdr_idx)
            2'h0: hdr_byte = e_di;
            2'h1: hdr_byte = e_wc[7:0];
            2'h2: hdr_byte = e_wc[15:8];
            default: hdr_byte = ecc_of({e_wc, e_di});
        endcase
    end

    assign rx_ready = rdy;

    // ------------------------------------------------------------
    // Forwarding engine
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= CSF_ST_ALIGN;
            in_frame <= 1'b0;
            synced <= 1'b0;
            sync_fail <= 1'b0;
            fr_act <= 2'b00;
            fr_mode <= CSF_MODE_OFF;
            cur <= 1'b0;
            e_kind <= CSF_KIND_FS;
            hdr_idx <= 2'h0;
            hd_vc <= '0;
            hd_dt <= '0;
            hd_wc <= '0;
            crc <= CSF_CRC_SEED;
            pay_have <= 1'b0;
            pay_eop <= 1'b0;
            pay_byte <= 8'h00;
            tmo <= 12'h000;
            rdy <= 2'b00;
            tx <= '0;
        end else begin
            sync_fail <= 1'b0;
            tx.strobe <= 1'b0;
            // Drop beats of ports not taking part
            rdy <= (rdy & ~rx_valid) | keep_drop;
            case (state)
                CSF_ST_ALIGN: begin
                    for (int p = 0; p < 2; p++) begin
                        hd_vc[p] <= remap(port_map[p], rx_beat[p].vc);
                        hd_dt[p] <= rx_beat[p].dt;
                        hd_wc[p] <= rx_beat[p].wc;
                    end
                    hdr_idx <= 2'h0;
                    if ((rdy & ~drop_mask) != 2'b00) begin
                        // Wait for pending take of a head
                    end else if (!run && !in_frame) begin
                        synced <= 1'b0;
                    end else if (!in_frame) begin
                        if (all_fs) begin
                            fr_act <= act;
                            fr_mode <= mode;
                            rdy <= keep_drop | act;
                            e_kind <= CSF_KIND_FS;
                            cur <= lowest(act);
                            in_frame <= 1'b1;
                            synced <= 1'b1;
                            state <= CSF_ST_HDR;
                        end else begin
                            rdy <= keep_drop | (act & rx_valid & ~h_fs);
                        end
                    end else if (all_head) begin
                        tmo <= 12'h000;
                        if (all_line) begin
                            e_kind <= CSF_KIND_LINE;
                            cur <= lowest(fr_act);
                            state <= CSF_ST_HDR;
                        end else if (all_fe) begin
                            e_kind <= CSF_KIND_FE;
                            cur <= lowest(fr_act);
                            rdy <= keep_drop | fr_act;
                            state <= CSF_ST_HDR;
                        end else begin
                            sync_fail <= 1'b1;
                            synced <= 1'b0;
                            in_frame <= 1'b0;
                        end
                    end else if (tmo == CSF_TMO_LAST) begin
                        tmo <= 12'h000;
                        sync_fail <= 1'b1;
                        synced <= 1'b0;
                        in_frame <= 1'b0;
                    end else begin
                        tmo <= tmo + 12'h001;
                    end
                end
                CSF_ST_HDR: begin
                    if (slot) begin
                        tx <= '{strobe: 1'b1, sop: hdr_idx == 2'h0,
                            eop: hdr_idx == 2'h3 && !e_long,
                            data: hdr_byte};
                        hdr_idx <= hdr_idx + 2'h1;
                        if (hdr_idx == 2'h3) begin
                            crc <= CSF_CRC_SEED;
                            state <= e_long ? CSF_ST_PAY : CSF_ST_NEXT;
                        end
                    end
                end
                CSF_ST_PAY: begin
                    if (!pay_have && !rdy[cur]) begin
                        rdy[cur] <= 1'b1;
                    end
                    if (rdy[cur] && rx_valid[cur]) begin
                        pay_have <= 1'b1;
                        pay_byte <= rx_beat[cur].data;
                        pay_eop <= rx_beat[cur].eop;
                    end
                    if (slot && pay_have) begin
                        tx <= '{strobe: 1'b1, sop: 1'b0, eop: 1'b0,
                            data: pay_byte};
                        crc <= crc_byte(crc, pay_byte);
                        pay_have <= 1'b0;
                        if (pay_eop) begin
                            // Line y of port 0 then port 1
                            if (fr_mode == CSF_MODE_CONCAT && !cur
                                && fr_act[1]) begin
                                cur <= 1'b1;
                            end else begin
                                state <= CSF_ST_CRC;
                            end
                        end
                    end
                end
                CSF_ST_CRC: begin
                    if (slot) begin
                        tx <= '{strobe: 1'b1, sop: 1'b0,
                            eop: hdr_idx == 2'h1,
                            data: hdr_idx == 2'h0 ? crc[7:0] : crc[15:8]};
                        hdr_idx <= hdr_idx + 2'h1;
                        if (hdr_idx == 2'h1) begin
                            state <= CSF_ST_NEXT;
                        end
                    end
                end
                CSF_ST_NEXT: begin
                    hdr_idx <= 2'h0;
                    if (more) begin
                        // Own packet for the next port
                        cur <= 1'b1;
                        state <= CSF_ST_HDR;
                    end else begin
                        if (e_kind == CSF_KIND_FE) begin
                            in_frame <= 1'b0;
                        end
                        tmo <= 12'h000;
                        state <= CSF_ST_ALIGN;
                    end
                end
                default: state <= CSF_ST_ALIGN;
            endcase
        end
    end

endmodule

`default_nettype wire

// >>> verification/csf_sync_forward_checker.sv
`timescale 1ns/100ps
`default_nettype none
module csf_sync_forward_checker
    import csf_pkg::*;
(
    // Design ports
    input wire logic core_clk,
    input wire logic rst_n,
    input wire csf_reg_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire csf_rx_s [1:0] rx_beat,
    input wire logic [1:0] rx_valid,
    input wire logic [1:0] rx_ready,
    input wire logic tx_byte_clk,
    input wire csf_tx_s tx,
    input wire logic tx_enable,
    input wire logic [1:0] tx_lane_sel,
    input wire logic fwd_synced
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr(logic [7:0] a); reg_req.wr && reg_req.addr == a; endsequence
    sequence s_rd(logic [7:0] a); reg_req.rd && reg_req.addr == a; endsequence
    a_csi_on:
    assert property (s_wr(8'h33) ##0 reg_req.wdata == 8'h01 |-> ##[1:2]
        tx_enable && tx_lane_sel == 2'h0) else $error("csi enable late");
    a_idle_tx:
    assert property (!tx_enable |-> !tx.strobe) else $error("byte while off");
    a_mode_back:
    assert property (s_wr(8'h21) ##2 s_rd(8'h21) |=> reg_rdata ==
        $past(reg_req.wdata, 3)) else $error("mode readback");
    a_port_back:
    assert property (s_wr(8'h20) ##2 s_rd(8'h20) |=> reg_rdata ==
        $past(reg_req.wdata, 3)) else $error("port readback");
    a_status_pad:
    assert property (s_rd(8'h23) |=> reg_rdata[7:2] == 6'h00)
        else $error("status upper bits");
    a_ready_drop:
    assert property (|(rx_valid & rx_ready) |=>
        (rx_ready & $past(rx_valid & rx_ready)) == 2'b00) else $error("ready");
    a_strobe_gap:
    assert property (tx.strobe |=> !tx.strobe [*6]) else $error("strobe gap");
    a_data_hold:
    assert property (!tx.strobe |-> $stable(tx.data)) else $error("data moved");
endmodule
bind csf_sync_forward csf_sync_forward_checker csf_sync_forward_checker_i (
    .core_clk, .rst_n, .reg_req, .reg_rdata, .rx_beat, .rx_valid, .rx_ready,
    .tx_byte_clk, .tx, .tx_enable, .tx_lane_sel, .fwd_synced);
`default_nettype wire

// >>> verification/csf_csi_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
module csf_csi_rx_model
    import csf_pkg::*;
(
    // Transmit side
    input wire logic core_clk,
    input wire csf_tx_s tx,
    output logic byte_clk,
    // Header seen
    output logic hdr_stb,
    output logic [7:0] hdr_di,
    output logic [7:0] hdr_wcl,
    // Long packet length and footer verdict
    output logic pay_stb,
    output logic pay_bad
);
    logic in_hdr = 1'b0;
    logic [2:0] pos = 3'h0;
    logic [7:0] cnt = 8'h00;
    logic [15:0] c = 16'h0000;
    function automatic logic [15:0] crc(logic [15:0] r, logic [7:0] b);
        for (int i = 0; i < 8; i++)
            r = (r >> 1) ^ ((r[0] ^ b[i]) ? CSF_CRC_POLY : 16'h0000);
        return r;
    endfunction
    initial begin
        byte_clk = 1'b0;
        forever #160 byte_clk = ~byte_clk;
    end
    // Report identifier and low count byte of each header
    always @(posedge core_clk) begin
        hdr_stb <= tx.strobe && in_hdr && !tx.sop;
        // Payload plus footer must leave a zero remainder
        pay_stb <= tx.strobe && tx.eop && pos == 3'h4;
        pay_bad <= crc(c, tx.data) != 16'h0000 || cnt != hdr_wcl + 8'h01;
        if (tx.strobe) begin
            in_hdr <= tx.sop;
            pos <= tx.sop ? 3'h1 : (pos == 3'h4) ? pos : pos + 3'h1;
            c <= (pos == 3'h4) ? crc(c, tx.data) : CSF_CRC_SEED;
            cnt <= (pos == 3'h4) ? cnt + 8'h01 : 8'h00;
            if (tx.sop) hdr_di <= tx.data;
            else if (in_hdr) hdr_wcl <= tx.data;
        end
    end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
    import csf_pkg::*;
;
    logic core_clk, rst_n, byte_clk, hdr_stb, tx_enable, fwd_synced;
    logic pay_stb, pay_bad;
    csf_reg_req_s reg_req;
    csf_rx_s [1:0] rx_beat;
    logic [1:0] rx_valid, rx_ready, tx_lane_sel;
    logic [7:0] reg_rdata, hdr_di, hdr_wcl;
    csf_tx_s tx;
    logic [15:0] got[$];
    logic [15:0] cfg[6] = '{16'h4c01, 16'h72e4, 16'h4c12, 16'h70e5, 16'h3301,
        16'h2000};
    int failures = 0, tests_run = 0;
    csf_sync_forward csf_sync_forward_i (.core_clk, .rst_n, .reg_req,
        .reg_rdata, .rx_beat, .rx_valid, .rx_ready, .tx_byte_clk(byte_clk),
        .tx, .tx_enable, .tx_lane_sel, .fwd_synced);
    csf_csi_rx_model csf_csi_rx_model_i (.core_clk, .tx, .byte_clk, .hdr_stb,
        .hdr_di, .hdr_wcl, .pay_stb, .pay_bad);
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
        if (hdr_stb === 1'b1) got.push_back({hdr_di, hdr_wcl});
    always @(posedge core_clk)
        if (pay_stb === 1'b1)
            chk({15'h0, pay_bad}, 16'h0000);
    task stop_test;
        $display("checks %0d, failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(logic [15:0] g, logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task wr(logic [7:0] a, logic [7:0] d);
        @(negedge core_clk) reg_req = '{1'b1, 1'b0, a, d};
        @(negedge core_clk) reg_req = '0;
    endtask
    task rd(logic [7:0] a, logic [7:0] e);
        @(negedge core_clk) reg_req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk) reg_req = '0;
        chk({8'h00, reg_rdata}, {8'h00, e});
    endtask
    task automatic pkt(int p, csf_kind_e k, int n);
        csf_rx_s b;
        for (int i = 0; i < n; i++) begin
            b = '{i == 0, i == n - 1, k, 2'h0, (k == CSF_KIND_LINE) ? 6'h2a :
                {5'h0, k == CSF_KIND_FE}, 16'(n), 8'($urandom)};
            @(negedge core_clk) rx_beat[p] = b;
            rx_valid[p] = 1'b1;
            do @(posedge core_clk); while (rx_ready[p] !== 1'b1);
        end
        @(negedge core_clk) rx_valid[p] = 1'b0;
    endtask
    task automatic port(int p, csf_kind_e mid);
        pkt(p, CSF_KIND_FS, 1);
        repeat (2) pkt(p, mid, (mid == CSF_KIND_LINE) ? 2 : 1);
        pkt(p, CSF_KIND_FE, 1);
    endtask
    function automatic logic [15:0] exp_hdr(int m, int i, int n);
        logic fs, fe;
        fs = (m == 0) ? (i < 2) : (i == 0);
        fe = (m == 0) ? (i >= n - 2) : (i == n - 1);
        return {(m == 0) ? 2'(i % 2) : 2'h0, fs ? 6'h00 : fe ? 6'h01 : 6'h2a,
            (fs || fe) ? 8'h01 : (m == 1) ? 8'h04 : 8'h02};
    endfunction
    task automatic run(int m, logic [7:0] code);
        int n;
        n = (m == 0) ? 8 : (m == 2) ? 6 : 4;
        wr(8'h21, code);
        rd(8'h21, code);
        got.delete();
        fork port(0, CSF_KIND_LINE); port(1, CSF_KIND_LINE); join
        for (int i = 0; i < 3000 && got.size() < n; i++) @(posedge core_clk);
        repeat (100) @(posedge core_clk);
        chk(16'(got.size()), 16'(n));
        foreach (got[i])
            chk(got[i], exp_hdr(m, i, n));
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        stop_test;
    end
    initial begin
        rst_n = 1'b0;
        reg_req = '0;
        rx_beat = '0;
        rx_valid = 2'b00;
        void'($urandom(41));
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        rd(CSF_ADDR_PORT_CTL, CSF_PORT_CTL_RST);
        rd(CSF_ADDR_MODE_CTL, CSF_MODE_CTL_RST);
        rd(8'h40, 8'h00);
        foreach (cfg[i]) begin
            wr(cfg[i][15:8], cfg[i][7:0]);
            rd(cfg[i][15:8], cfg[i][7:0]);
        end
        run(0, 8'h04);
        rd(8'h23, 8'h01);
        chk({15'h0, fwd_synced}, 16'h0001);
        fork port(0, CSF_KIND_LINE); port(1, CSF_KIND_FE); join
        repeat (200) @(negedge core_clk);
        rd(8'h23, 8'h02);
        chk({15'h0, fwd_synced}, 16'h0000);
        rd(8'h23, 8'h00);
        run(1, 8'h3c);
        wr(8'h70, 8'he4);
        run(2, 8'h28);
        wr(8'h20, 8'h20);
        run(3, 8'h04);
        stop_test;
    end
endmodule
`default_nettype wire
